// ===== design/swc_pkg.sv
package swc_pkg;

  // ==========================================================
  // Sleep modes and sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    SWC_MODE_STANDBY = 2'h0,
    SWC_MODE_SERIAL = 2'h1,
    SWC_MODE_DEEP = 2'h2
  } swc_mode_type;

  // Gray codes along awake -> halt -> asleep -> power good -> taps
  typedef enum logic [2:0] {
    SWC_AWAKE = 3'h0,
    SWC_HALT = 3'h1,
    SWC_ASLEEP = 3'h3,
    SWC_PGOOD = 3'h2,
    SWC_TAP0 = 3'h6,
    SWC_TAP1 = 3'h7,
    SWC_TAP2 = 3'h5,
    SWC_RESET = 3'h4
  } swc_state_type;

  // ==========================================================
  // Wake sources travel together
  // ==========================================================
  typedef struct packed {
    logic sleepTimer;
    logic gpio;
    logic timer0;
    logic usb;
    logic serial;
    logic lowVoltage;
  } swc_wake_type;

  // ==========================================================
  // Constants
  // ==========================================================
  localparam int SWC_TIMER_WIDTH = 15;
  localparam logic [7:0] SWC_SLEEP_CLEAR_KEY = 8'h38;
  localparam logic [1:0] SWC_PGOOD_SLOW_CYCLES = 2'h3;
  localparam logic [1:0] SWC_WDT_ROLLOVERS = 2'h3;
  localparam logic [6:0] SWC_TAP_RESET = 7'h7f;
  localparam int SWC_CLOCK_MHZ = 20;
  // Tap times in microseconds, index by the 2-bit field
  localparam int SWC_T0_US [4] = '{10, 14, 20, 30};
  localparam int SWC_T1_US [4] = '{3, 4, 5, 10};
  localparam int SWC_T2_US [4] = '{1, 2, 5, 10};
  // Field positions in the tap configuration
  localparam int SWC_TAP_T0_LSB = 0;
  localparam int SWC_TAP_T1_LSB = 2;
  localparam int SWC_TAP_T2_LSB = 4;
  localparam int SWC_TAP_DBL_BIT = 6;
  localparam int SWC_TAP_CNT_WIDTH = 11;

endpackage : swc_pkg

// ===== design/swc_sleep_wakeup_controller.sv
// What this block does
// - Sleep request bit enters standby sleep
// - Keepalive or USB adds serial power enable
// - Serial sleep: start, 8-bit address, wake
// - Resleep mid-transfer: serial slave answers NAK
// - Crystal without presence flag stops slow clock
// - Standby wakes on timer, GPIO, timer0, USB
// - Serial adds I2C; deep wakes GPIO, USB
// - Low voltage in buzz starts wakeup from standby sleep only
// - Watchdog in standby: wake, then reset
// - Request release starts tapped wakeup sequence
// - Power good lasts three slow cycles
// - Three main-clock tap intervals time wakeup
// - Fifteen-bit sleep timer, off in deep
// - Debug stop halts the sleep timer
// - Periodic sleep timer interrupt at interval
// - Hardware resets zero the sleep timer
// - Key clears timer; any write clears watchdog
// - Pending interrupt blocks the sleep bit
// - Masks alone wake; pending exits immediately
// - Prefetched instruction runs before service
// - Interrupts before power-down are ignored
// - Three rollovers uncleared cause watchdog reset
// - Halt request, acknowledge, then power-down
`timescale 1ns/10ps

module swc_sleep_wakeup_controller (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // CPU sleep request and configuration
  input wire logic sleepRequestWrite,
  input wire logic serialKeepalive,
  input wire logic usbEnable,
  input wire logic crystalSelect,
  input wire logic crystalPresent,
  input wire logic lowSpeedOscOff,
  input wire logic [6:0] wakeupTapConfig,
  input wire logic [1:0] intervalSelect,
  input wire logic sleepTimerIntEnable,
  input wire logic debugMode,
  input wire logic cpuStop,
  // Watchdog clear register write
  input wire logic watchdogClearWrite,
  input wire logic [7:0] watchdogClearData,
  // Slow clock tick and buzz window
  input wire logic slowTick,
  input wire logic buzzActive,
  // Interrupt requests and masks
  input wire swc_pkg::swc_wake_type irqPending,
  input wire swc_pkg::swc_wake_type irqMask,
  input wire logic irqTakenAtBoundary,
  // Serial slave observation
  input wire logic serialStart,
  input wire logic serialByteDone,
  input wire logic [7:0] serialAddress,
  input wire logic [7:0] serialOwnAddress,
  input wire logic serialBusy,
  // CPU handshake
  input wire logic busHaltAcknowledge,
  output logic busHaltRequest,
  output logic powerDownSignal,
  // Status and control outputs
  output logic sleepBit,
  output logic serialPowerEnable,
  output logic slowClockRun,
  output logic [14:0] sleepTimerCount,
  output logic sleepTimerIrq,
  output logic serialWakeIrq,
  output logic serialNak,
  output logic watchdogResetEvent,
  output logic wakeDone
);

  // ==========================================================
  // Declarations
  // ==========================================================
  swc_pkg::swc_state_type state;
  swc_pkg::swc_mode_type mode;
  logic [1:0] pgoodCount;
  logic [10:0] tapCount;
  logic [1:0] wdtCount;
  logic wdtPending;
  logic wakeNow;
  logic clkEnNeg;
  logic rollover;
  logic intervalTick;
  logic timerRun;
  logic [10:0] tapLimit;
  logic [1:0] tapSelT0;
  logic [1:0] tapSelT1;
  logic [1:0] tapSelT2;
  logic tapDouble;
  logic serialAddrPhase;
  logic [14:0] next_sleepTimerCount;

  // Tap interval in main-clock cycles, doubled when asked
  function automatic logic [10:0] tapCycles(input int us, input logic dbl);
    int c;
    c = us * swc_pkg::SWC_CLOCK_MHZ;
    if (dbl) begin
      c = c * 2;
    end
    return 11'(c - 1);
  endfunction : tapCycles

  // ==========================================================
  // Wake qualification
  // ==========================================================
  // Wake uses per-source masks, the buzz window for low voltage, never the global enable
  always_comb begin
    wakeNow = 1'b0;
    unique case (mode)
      swc_pkg::SWC_MODE_STANDBY: begin
        wakeNow = |{irqPending.sleepTimer & irqMask.sleepTimer,
                    irqPending.gpio & irqMask.gpio,
                    irqPending.timer0 & irqMask.timer0,
                    irqPending.usb & irqMask.usb,
                    irqPending.lowVoltage & buzzActive};
      end
      swc_pkg::SWC_MODE_SERIAL: begin
        wakeNow = |{irqPending.sleepTimer & irqMask.sleepTimer,
                    irqPending.gpio & irqMask.gpio,
                    irqPending.timer0 & irqMask.timer0,
                    irqPending.usb & irqMask.usb,
                    irqPending.serial & irqMask.serial};
      end
      default: begin
        wakeNow = |{irqPending.gpio & irqMask.gpio,
                    irqPending.usb & irqMask.usb};
      end
    endcase
  end

  // Tap selects sliced at the field positions of the configuration
  // A config change mid-sequence moves the limit of the live tap and of the taps after it
  always_comb begin
    tapSelT0 = wakeupTapConfig[swc_pkg::SWC_TAP_T0_LSB +: 2];
    tapSelT1 = wakeupTapConfig[swc_pkg::SWC_TAP_T1_LSB +: 2];
    tapSelT2 = wakeupTapConfig[swc_pkg::SWC_TAP_T2_LSB +: 2];
    tapDouble = wakeupTapConfig[swc_pkg::SWC_TAP_DBL_BIT];
  end

  // Tap limit from the configuration field of the current phase
  always_comb begin
    tapLimit = tapCycles(swc_pkg::SWC_T0_US[tapSelT0], tapDouble);
    if (state == swc_pkg::SWC_TAP1) begin
      tapLimit = tapCycles(swc_pkg::SWC_T1_US[tapSelT1], tapDouble);
    end else if (state == swc_pkg::SWC_TAP2) begin
      tapLimit = tapCycles(swc_pkg::SWC_T2_US[tapSelT2], tapDouble);
    end
  end

  // ==========================================================
  // Sleep entry and wakeup sequencer
  // ==========================================================
  // Half-cycle stand-in: power-down waits one cycle after ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= swc_pkg::SWC_AWAKE;
      mode <= swc_pkg::SWC_MODE_STANDBY;
      pgoodCount <= 2'h0;
      tapCount <= 11'h0;
      clkEnNeg <= 1'b0;
    end else begin
      unique case (state)
        swc_pkg::SWC_AWAKE: begin
          // A pending enabled interrupt keeps the bit from setting
          if (sleepRequestWrite && !irqTakenAtBoundary && !wakeNow) begin
            state <= swc_pkg::SWC_HALT;
            clkEnNeg <= 1'b0;
            if (serialKeepalive || usbEnable) begin
              mode <= swc_pkg::SWC_MODE_SERIAL;
            end else if (lowSpeedOscOff && !crystalSelect) begin
              mode <= swc_pkg::SWC_MODE_DEEP;
            end else begin
              mode <= swc_pkg::SWC_MODE_STANDBY;
            end
          end
        end
        swc_pkg::SWC_HALT: begin
          // Interrupts in this window are ignored
          if (busHaltAcknowledge) begin
            clkEnNeg <= 1'b1;
          end
          if (clkEnNeg) begin
            state <= swc_pkg::SWC_ASLEEP;
          end
        end
        swc_pkg::SWC_ASLEEP: begin
          if (wakeNow || wdtPending) begin
            state <= swc_pkg::SWC_PGOOD;
            pgoodCount <= 2'h0;
          end
        end
        swc_pkg::SWC_PGOOD: begin
          if (slowTick) begin
            pgoodCount <= pgoodCount + 2'h1;
            if (pgoodCount == swc_pkg::SWC_PGOOD_SLOW_CYCLES - 2'h1) begin
              state <= swc_pkg::SWC_TAP0;
              tapCount <= 11'h0;
            end
          end
        end
        swc_pkg::SWC_TAP0, swc_pkg::SWC_TAP1: begin
          tapCount <= tapCount + 11'h1;
          if (tapCount == tapLimit) begin
            tapCount <= 11'h0;
            state <= (state == swc_pkg::SWC_TAP0) ? swc_pkg::SWC_TAP1
                                                 : swc_pkg::SWC_TAP2;
          end
        end
        swc_pkg::SWC_TAP2: begin
          tapCount <= tapCount + 11'h1;
          if (tapCount == tapLimit) begin
            // Watchdog reset waits for the full wakeup
            state <= wdtPending ? swc_pkg::SWC_RESET
                                : swc_pkg::SWC_AWAKE;
          end
        end
        swc_pkg::SWC_RESET: begin
          state <= swc_pkg::SWC_AWAKE;
        end
      endcase
    end
  end

  // Handshake and status outputs follow the state
  always_comb begin
    busHaltRequest = (state == swc_pkg::SWC_HALT) ||
                     (state == swc_pkg::SWC_ASLEEP);
    powerDownSignal = (state == swc_pkg::SWC_ASLEEP);
    sleepBit = (state != swc_pkg::SWC_AWAKE) &&
               (state != swc_pkg::SWC_RESET);
    serialPowerEnable = sleepBit && (mode == swc_pkg::SWC_MODE_SERIAL);
    wakeDone = (state == swc_pkg::SWC_AWAKE);
    // Crystal picked with no crystal fitted leaves the slow clock dead
    slowClockRun = !(crystalSelect && !crystalPresent) &&
                   !(powerDownSignal &&
                     mode == swc_pkg::SWC_MODE_DEEP);
  end

  // ==========================================================
  // Serial keepalive address watch
  // ==========================================================
  // Only address phase works in sleep; later bytes are not watched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialAddrPhase <= 1'b0;
      serialWakeIrq <= 1'b0;
      serialNak <= 1'b0;
    end else begin
      serialWakeIrq <= 1'b0;
      if (powerDownSignal && mode == swc_pkg::SWC_MODE_SERIAL) begin
        if (serialStart) begin
          serialAddrPhase <= 1'b1;
        end else if (serialAddrPhase && serialByteDone) begin
          serialAddrPhase <= 1'b0;
          serialWakeIrq <= (serialAddress == serialOwnAddress);
        end
      end
      // Sleeping again mid-transfer disables the slave
      if (state == swc_pkg::SWC_HALT && serialBusy) begin
        serialNak <= 1'b1;
      end else if (serialStart || wakeDone) begin
        serialNak <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sleep timer
  // ==========================================================
  always_comb begin
    timerRun = slowTick && slowClockRun && !(debugMode && cpuStop);
    next_sleepTimerCount = sleepTimerCount + 15'h1;
  end

  // Interval tick taps bits 5, 8, 11 or 14 of the count
  always_comb begin
    rollover = timerRun && (&sleepTimerCount);
    unique case (intervalSelect)
      2'h0: intervalTick = timerRun && (&sleepTimerCount[5:0]);
      2'h1: intervalTick = timerRun && (&sleepTimerCount[8:0]);
      2'h2: intervalTick = timerRun && (&sleepTimerCount[11:0]);
      2'h3: intervalTick = rollover;
    endcase
  end

  // Count runs awake and asleep, but stops in deep sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepTimerCount <= 15'h0;
    end else if (watchdogResetEvent) begin
      sleepTimerCount <= 15'h0;
    end else if (watchdogClearWrite &&
                 watchdogClearData == swc_pkg::SWC_SLEEP_CLEAR_KEY) begin
      sleepTimerCount <= 15'h0;
    end else if (timerRun) begin
      sleepTimerCount <= next_sleepTimerCount;
    end
  end

  // Periodic interrupt pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepTimerIrq <= 1'b0;
    end else begin
      sleepTimerIrq <= intervalTick && sleepTimerIntEnable;
    end
  end

  // ==========================================================
  // Watchdog
  // ==========================================================
  // Timeout lands two to three full-count rollovers after a lone clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtCount <= 2'h0;
      wdtPending <= 1'b0;
      watchdogResetEvent <= 1'b0;
    end else begin
      watchdogResetEvent <= 1'b0;
      if (watchdogClearWrite) begin
        wdtCount <= 2'h0;
      end else if (rollover) begin
        if (wdtCount == swc_pkg::SWC_WDT_ROLLOVERS - 2'h1) begin
          wdtCount <= 2'h0;
          wdtPending <= 1'b1;
        end else begin
          wdtCount <= wdtCount + 2'h1;
        end
      end
      // Asleep the reset is deferred until wakeup has run
      if (wdtPending && (state == swc_pkg::SWC_AWAKE ||
                         state == swc_pkg::SWC_RESET)) begin
        wdtPending <= 1'b0;
        watchdogResetEvent <= 1'b1;
      end
    end
  end

endmodule : swc_sleep_wakeup_controller

// ===== verification/swc_sleep_wakeup_controller_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the sleep and wakeup controller
module swc_sleep_wakeup_controller_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stimulus seen at the ports
  input wire logic sleepRequestWrite,
  input wire logic irqTakenAtBoundary,
  input wire swc_pkg::swc_wake_type irqPending,
  input wire swc_pkg::swc_wake_type irqMask,
  input wire logic serialKeepalive,
  input wire logic crystalSelect,
  input wire logic crystalPresent,
  input wire logic debugMode,
  input wire logic cpuStop,
  input wire logic watchdogClearWrite,
  input wire logic [7:0] watchdogClearData,
  input wire logic busHaltAcknowledge,
  // Outputs under watch
  input wire logic busHaltRequest,
  input wire logic powerDownSignal,
  input wire logic wakeDone,
  input wire logic serialPowerEnable,
  input wire logic slowClockRun,
  input wire logic [14:0] sleepTimerCount,
  input wire logic watchdogResetEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_halt_answer: assert property (
    wakeDone && sleepRequestWrite && !irqTakenAtBoundary
    && irqPending == '0 |=> busHaltRequest) else $error("no halt");
  chk_boundary_block: assert property (
    wakeDone && sleepRequestWrite && irqTakenAtBoundary
    |=> !busHaltRequest) else $error("halt despite interrupt");
  chk_pd_after_ack: assert property (
    $rose(powerDownSignal) |-> busHaltRequest
    && $past(busHaltAcknowledge)) else $error("early power-down");
  chk_ack_to_pd: assert property (
    busHaltRequest && busHaltAcknowledge && !powerDownSignal
    |-> ##[1:2] powerDownSignal) else $error("power-down late");
  chk_serial_power: assert property (
    powerDownSignal && serialKeepalive |-> serialPowerEnable)
    else $error("serial power off");
  chk_gpio_wake: assert property (
    powerDownSignal && irqPending.gpio && irqMask.gpio
    |=> !powerDownSignal) else $error("gpio did not wake");
  chk_slow_stop: assert property (
    crystalSelect && !crystalPresent |-> !slowClockRun)
    else $error("slow clock runs");
  chk_key_clear: assert property (
    watchdogClearWrite && watchdogClearData == 8'h38
    |=> sleepTimerCount == '0) else $error("timer not cleared");
  chk_timer_halt: assert property (
    debugMode && cpuStop && !watchdogClearWrite
    |=> $stable(sleepTimerCount) || watchdogResetEvent)
    else $error("timer moved in debug stop");
  chk_wake_hold: assert property (
    $fell(powerDownSignal) |-> (!wakeDone) [*8])
    else $error("wakeup too short");
endmodule : swc_sleep_wakeup_controller_chk
bind swc_sleep_wakeup_controller
  swc_sleep_wakeup_controller_chk chk (.*);

// ===== verification/swc_cpu_model.sv
`timescale 1ns/10ps
// ==========================================================
// CPU side of the halt handshake
module swc_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake
  input wire logic [3:0] ackWait,
  input wire logic busHaltRequest,
  output logic busHaltAcknowledge
);
  logic [3:0] waitCount;
  // Acknowledge ackWait + 1 edges after the request; zero is a prompt CPU
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCount <= 4'h0;
      busHaltAcknowledge <= 1'b0;
    end else if (!busHaltRequest) begin
      waitCount <= 4'h0;
      busHaltAcknowledge <= 1'b0;
    end else if (waitCount >= ackWait) begin
      busHaltAcknowledge <= 1'b1;
    end else begin
      waitCount <= waitCount + 4'h1;
    end
  end
endmodule : swc_cpu_model

// ===== verification/swc_sleep_wakeup_controller_test.sv
`timescale 1ns/10ps
// ==========================================================
// Bench for the sleep and wakeup controller
module swc_sleep_wakeup_controller_test;
  logic clk, rst, sleepRequestWrite, serialKeepalive, usbEnable;
  logic crystalSelect, crystalPresent, lowSpeedOscOff, debugMode;
  logic sleepTimerIntEnable, cpuStop, watchdogClearWrite, slowTick;
  logic buzzActive, irqTakenAtBoundary, serialStart, serialByteDone;
  logic serialBusy, busHaltAcknowledge, busHaltRequest, sleepBit;
  logic powerDownSignal, serialPowerEnable, slowClockRun, seen;
  logic sleepTimerIrq, serialWakeIrq, serialNak, wakeDone, tickOn;
  logic watchdogResetEvent;
  logic wdtSeen = 1'b0;
  logic [6:0] wakeupTapConfig;
  logic [1:0] intervalSelect;
  logic [7:0] watchdogClearData, serialAddress, serialOwnAddress;
  logic [14:0] sleepTimerCount;
  logic [3:0] ackWait;
  logic [2:0] tickPhase;
  swc_pkg::swc_wake_type irqPending, irqMask;
  int err_count = 0;
  int cmp_count = 0;
  int tickSeen = 0;
  int n, base;
  logic [6:0] taps [3] = '{7'h00, 7'h15, 7'h7f};
  int tapLen [3] = '{280, 400, 2000};
  // Wake sources per mode, sleep timer first
  logic [5:0] wakeTab [3] = '{6'h3d, 6'h3e, 6'h14};

  swc_sleep_wakeup_controller dut (.*);
  swc_cpu_model cpu (.*);

  // ==========================================================
  // Clocks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Slow strobe every eighth cycle keeps runs short
  always @(negedge clk) begin
    tickPhase <= tickPhase + 3'h1;
    slowTick <= tickOn && tickPhase == 3'h7;
    // Far too few rollovers in this run for any watchdog reset
    if (watchdogResetEvent === 1'b1) wdtSeen <= 1'b1;
  end
  // Strobes as the controller samples them
  always @(posedge clk) begin
    if (slowTick) tickSeen++;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic clearWrite(input logic [7:0] d);
    watchdogClearData = d;
    watchdogClearWrite = 1'b1;
    tick(1);
    watchdogClearWrite = 1'b0;
    tick(1);
  endtask : clearWrite
  // Bounded waits so a stuck sequencer cannot hang the run
  task automatic waitPd();
    n = 0;
    while (powerDownSignal !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
  endtask : waitPd
  task automatic goSleep();
    sleepRequestWrite = 1'b1;
    tick(1);
    sleepRequestWrite = 1'b0;
    waitPd();
  endtask : goSleep
  task automatic wake(input int s);
    irqPending = swc_pkg::swc_wake_type'(6'h20 >> s);
    tick(2);
    irqPending = '0;
  endtask : wake
  task automatic waitDone();
    n = 0;
    while (wakeDone !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
  endtask : waitDone
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    {sleepRequestWrite, serialKeepalive, usbEnable, crystalSelect} = '0;
    {lowSpeedOscOff, sleepTimerIntEnable, debugMode, cpuStop} = '0;
    {watchdogClearWrite, buzzActive, irqTakenAtBoundary, tickOn} = '0;
    {serialStart, serialByteDone, serialBusy, slowTick} = '0;
    {tickPhase, ackWait, intervalSelect, wakeupTapConfig} = '0;
    {watchdogClearData, serialAddress} = '0;
    crystalPresent = 1'b1;
    serialOwnAddress = 8'h5b;
    irqPending = '0;
    irqMask = '1;
    tick(4);
    rst = 1'b0;
    check("count", 0, sleepTimerCount);
    irqTakenAtBoundary = 1'b1;
    goSleep();
    check("halt", 0, busHaltRequest);
    irqTakenAtBoundary = 1'b0;
    irqPending.gpio = 1'b1;
    goSleep();
    check("halt", 0, busHaltRequest);
    irqPending = '0;
    $display("test boundary done");
    // Slow acknowledge leaves room for an ignored interrupt
    tickOn = 1'b1;
    ackWait = 4'h4;
    for (int i = 0; i < 3; i++) begin
      wakeupTapConfig = taps[i];
      sleepRequestWrite = 1'b1;
      tick(1);
      sleepRequestWrite = 1'b0;
      check("halt", 1, busHaltRequest);
      check("sleep bit", 1, sleepBit);
      irqPending.gpio = 1'b1;
      tick(1);
      irqPending = '0;
      waitPd();
      check("pd", 1, powerDownSignal);
      wake(1);
      check("pd", 0, powerDownSignal);
      waitDone();
      seen = n inside {[tapLen[i] + 10:tapLen[i] + 30]};
      check("wake time", 1, seen);
    end
    $display("test taps done");
    ackWait = 4'h0;
    buzzActive = 1'b1;
    wakeupTapConfig = 7'h00;
    for (int m = 0; m < 3; m++) begin
      serialKeepalive = m == 1;
      lowSpeedOscOff = m == 2;
      for (int s = 0; s < 6; s++) begin
        if (s == 5 && m != 0) continue;
        goSleep();
        check("serial power", m == 1, serialPowerEnable);
        wake(s);
        seen = !powerDownSignal;
        check("wake", wakeTab[m][5 - s], seen);
        if (powerDownSignal === 1'b1) wake(1);
        waitDone();
      end
    end
    lowSpeedOscOff = 1'b0;
    $display("test sources done");
    // Busy serial slave during the halt must answer with NAK
    usbEnable = 1'b1;
    ackWait = 4'h3;
    sleepRequestWrite = 1'b1;
    tick(1);
    sleepRequestWrite = 1'b0;
    serialBusy = 1'b1;
    waitPd();
    serialBusy = 1'b0;
    check("serial power", 1, serialPowerEnable);
    check("nak", 1, serialNak);
    for (int a = 0; a < 2; a++) begin
      serialAddress = 8'h5a + 8'(a);
      serialStart = 1'b1;
      tick(1);
      serialStart = 1'b0;
      serialByteDone = 1'b1;
      tick(1);
      serialByteDone = 1'b0;
      seen = serialWakeIrq;
      tick(1);
      seen = seen | serialWakeIrq;
      check("serial irq", a, seen);
    end
    wake(4);
    waitDone();
    usbEnable = 1'b0;
    $display("test serial done");
    tickOn = 1'b0;
    tick(10);
    clearWrite(8'h38);
    check("count", 0, sleepTimerCount);
    base = tickSeen;
    tickOn = 1'b1;
    tick(100);
    tickOn = 1'b0;
    tick(10);
    check("count", tickSeen - base, sleepTimerCount);
    // Hardware reset mid-run must zero a stopped, nonzero count
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    check("count", 0, sleepTimerCount);
    {debugMode, cpuStop, tickOn} = '1;
    base = sleepTimerCount;
    tick(50);
    check("count", base, sleepTimerCount);
    {debugMode, cpuStop, tickOn} = '0;
    tick(10);
    base = sleepTimerCount;
    clearWrite(8'h12);
    check("count", base, sleepTimerCount);
    sleepTimerIntEnable = 1'b1;
    // Two shortest intervals: 64 and 512 slow ticks
    for (int p = 0; p < 2; p++) begin
      tickOn = 1'b0;
      intervalSelect = 2'(p);
      clearWrite(8'h38);
      base = tickSeen;
      tickOn = 1'b1;
      n = 0;
      while (sleepTimerIrq !== 1'b1 && n < 5000) begin
        tick(1);
        n++;
      end
      seen = (tickSeen - base) inside {[(64 << 3 * p) - 1:(64 << 3 * p) + 1]};
      check("period", 1, seen);
    end
    {crystalSelect, crystalPresent} = 2'h2;
    tick(1);
    check("slow run", 0, slowClockRun);
    crystalPresent = 1'b1;
    tick(1);
    check("slow run", 1, slowClockRun);
    check("wdt reset", 0, wdtSeen);
    $display("test timer done");
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : swc_sleep_wakeup_controller_test
